// file: dv/dram_impedance_calibration_sequencer_test.sv
// self-checking bench joining controller and device over the calibration link
`timescale 1ns/1ps
module dram_impedance_calibration_sequencer_test;
    localparam int INIT = 8;
    localparam int OPER = 6;
    localparam int SHORT = 4;
    localparam int SRX = 34;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_long = 1'b0;
    logic sr_exit = 1'b0;
    logic banks_idle = 1'b1;
    logic peer_rank_busy = 1'b0;
    logic [7:0] engine_code = 8'h00;
    logic [7:0] io_code;
    logic io_update, cal_current_en, cal_is_long, first_done, req_ready, rank_busy, done;
    int failures = 0;
    int samples_checked = 0;
    int lat;
    zq_link_if link ();
    zq_controller #(.INIT_CYC(INIT), .OPER_CYC(OPER), .SHORT_CYC(SHORT), .PRE_CYC(3),
        .SRX_CYC(SRX)) i_zq_controller (.clk, .rst_n, .link(link), .req_valid, .req_long,
        .req_ready, .sr_exit, .banks_idle, .peer_rank_busy, .rank_busy, .done);
    zq_device #(.INIT_CYC(INIT), .OPER_CYC(OPER), .SHORT_CYC(SHORT)) i_zq_device (.clk,
        .rst_n, .link(link), .engine_code, .io_code, .io_update, .cal_current_en,
        .cal_is_long, .first_done);
    zq_link_properties #(.INIT_CYC(INIT), .OPER_CYC(OPER), .SHORT_CYC(SHORT))
        i_zq_link_properties (.clk(clk), .rst_n(rst_n), .cal_cmd(link.cal_cmd),
        .a10(link.a10), .cke(link.cke), .odt(link.odt), .dq_oe(link.dq_oe),
        .banks_precharged(link.banks_precharged), .cal_busy(link.cal_busy));
    always #2.5 clk = ~clk;
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_eq
    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // outputs are sampled on the falling edge, clear of the launch edge
    task automatic do_cal(input logic lng, input logic [7:0] code, input int win,
        output int lat);
        int busy;
        int upd;
        int rb;
        int cur;
        int n;
        busy = 0;
        upd = 0;
        rb = 0;
        cur = 0;
        lat = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_long <= lng;
        engine_code <= code;
        for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        for (n = 0; n < 200 && link.cal_cmd !== 1'b1; n++) begin
            @(negedge clk);
            lat++;
            upd += int'(io_update === 1'b1);
        end
        check_eq(link.a10, lng);
        check_eq(upd, 0);
        for (n = 0; n < 200 && done !== 1'b1; n++) begin
            @(negedge clk);
            busy += int'(link.cal_busy === 1'b1);
            rb += int'(rank_busy === 1'b1);
            cur += int'(cal_current_en === 1'b1);
            upd += int'(io_update === 1'b1);
        end
        repeat (3) begin
            @(negedge clk);
            busy += int'(link.cal_busy === 1'b1);
        end
        check_eq(busy, win);
        check_eq(upd, 1);
        check_eq(rb, win);
        // engine current is on through the run phase only, off in the transfer cycle
        check_eq(cur, win - 1);
        check_eq({io_code, cal_is_long, cal_current_en}, {code, lng, 1'b0});
    endtask : do_cal
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        do_cal(1'b0, 8'h3c, SHORT, lat);
        check_eq(first_done, 1'b0);
        do_cal(1'b1, 8'ha5, INIT, lat);
        check_eq(first_done, 1'b1);
        do_cal(1'b1, 8'h5a, OPER, lat);
        @(posedge clk);
        sr_exit <= 1'b1;
        @(posedge clk);
        sr_exit <= 1'b0;
        do_cal(1'b0, 8'h0f, SHORT, lat);
        // lat runs from the taken request, which lands three edges after the exit pulse
        check_eq(lat + 3 >= SRX, 1'b1);
        @(posedge clk);
        peer_rank_busy <= 1'b1;
        fork
            do_cal(1'b1, 8'hc3, OPER, lat);
            begin
                repeat (20) @(posedge clk);
                peer_rank_busy <= 1'b0;
            end
        join
        check_eq(lat >= 15, 1'b1);
        @(posedge clk);
        banks_idle <= 1'b0;
        req_valid <= 1'b1;
        repeat (6) begin
            @(negedge clk);
            check_eq({req_ready, link.cal_cmd}, 2'b00);
        end
        @(posedge clk);
        banks_idle <= 1'b1;
        req_valid <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        do_cal(1'b1, 8'h99, INIT, lat);
        final_report();
    end
    initial begin
        #20000;
        failures++;
        final_report();
    end
endmodule : dram_impedance_calibration_sequencer_test

// file: dv/zq_link_properties.sv
// concurrent checks on the calibration link between controller and device
`timescale 1ns/1ps
module zq_link_properties #(
    parameter int INIT_CYC = 512,
    parameter int OPER_CYC = 256,
    parameter int SHORT_CYC = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cal_cmd,
    input wire logic a10,
    input wire logic cke,
    input wire logic odt,
    input wire logic dq_oe,
    input wire logic banks_precharged,
    input wire logic cal_busy
);
    logic [15:0] cnt_ff;
    logic long_ff;
    logic first_ff;
    wire take = cal_cmd && !cal_busy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cnt_ff holds the busy length at the edge where busy is first seen low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_ff <= 16'h0000;
        else if (take) cnt_ff <= 16'h0000;
        else if (cal_busy) cnt_ff <= cnt_ff + 16'h0001;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) long_ff <= 1'b0;
        else if (take) long_ff <= a10;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) first_ff <= 1'b1;
        else if ($fell(cal_busy) && long_ff) first_ff <= 1'b0;
    end
    chk_cke_held: assert property (cke) else $error("cke dropped");
    chk_odt_off: assert property (cal_busy |-> !odt) else $error("odt on");
    chk_dq_hiz: assert property (cal_busy |-> !dq_oe) else $error("dq driven");
    chk_channel_quiet: assert property (cal_busy |-> !cal_cmd) else $error("cmd in window");
    chk_banks_ready: assert property (cal_cmd |-> banks_precharged) else $error("banks");
    chk_busy_start: assert property (take |=> cal_busy) else $error("no busy");
    chk_no_self_cal: assert property ($rose(cal_busy) |-> $past(cal_cmd)) else $error("self");
    chk_init_window: assert property ($fell(cal_busy) && long_ff && first_ff
        |-> cnt_ff == INIT_CYC) else $error("initial window length");
    chk_oper_window: assert property ($fell(cal_busy) && long_ff && !first_ff
        |-> cnt_ff == OPER_CYC) else $error("operational window length");
    chk_short_window: assert property ($fell(cal_busy) && !long_ff
        |-> cnt_ff == SHORT_CYC) else $error("short window length");
    cov_first_long: cover property (take && a10 && first_ff);
    cov_later_long: cover property (take && a10 && !first_ff);
    cov_short: cover property (take && !a10);
endmodule : zq_link_properties

// file: verilog/zq_cfg.svh
// timing counts and counter width for the impedance calibration link
// Behaviour
// RULE1 - long command performs initial power-up calibration
// RULE2 - controller may issue long command anytime later
// RULE3 - long command runs engine, then updates IO
// RULE4 - first long after reset gets initial window
// RULE5 - later long commands get operational window
// RULE6 - short command calibrates within short window
// RULE7 - controller keeps channel quiet during window
// RULE8 - device switches calibration current off when done
// RULE9 - all banks precharged, precharge period met first
// RULE10 - calibration may overlap lock after self refresh
// RULE11 - no self calibration after self-refresh exit
// RULE12 - no calibration before self-refresh exit delay
// RULE13 - shared resistor: rank windows never overlap
// RULE14 - CKE held high throughout every window
// RULE15 - termination disabled during calibration
// RULE16 - DQ outputs high impedance during calibration
// RULE17 - A10 high selects long, low short
// RULE18 - windows are counted cycles; channel busy meanwhile
`ifndef ZQ_CFG_SVH
`define ZQ_CFG_SVH
`define ZQ_CLK_MHZ 200
`define ZQ_INIT_CYC 512
`define ZQ_OPER_CYC 256
`define ZQ_SHORT_CYC 64
`define ZQ_PRECHARGE_NS 14
`define ZQ_PRECHARGE_CYC ((`ZQ_PRECHARGE_NS * `ZQ_CLK_MHZ + 999) / 1000)
`define ZQ_SR_EXIT_NS 170
`define ZQ_SR_EXIT_CYC ((`ZQ_SR_EXIT_NS * `ZQ_CLK_MHZ + 999) / 1000)
`define ZQ_CNT_W 12
`define ZQ_SETTLE_CYC 4
`endif

// file: verilog/zq_controller.sv
// controller end: issues calibration commands under the channel preconditions
`timescale 1ns/1ps
`include "zq_cfg.svh"
module zq_controller import zq_pkg::*; #(
    parameter int CNT_W = `ZQ_CNT_W,
    parameter int INIT_CYC = `ZQ_INIT_CYC,
    parameter int OPER_CYC = `ZQ_OPER_CYC,
    parameter int SHORT_CYC = `ZQ_SHORT_CYC,
    parameter int PRE_CYC = `ZQ_PRECHARGE_CYC,
    parameter int SRX_CYC = `ZQ_SR_EXIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    zq_link_if.ctrl link,
    input wire logic req_valid,
    input wire logic req_long,
    output logic req_ready,
    input wire logic sr_exit,
    input wire logic banks_idle,
    input wire logic peer_rank_busy,
    output logic rank_busy,
    output logic done
);
    ctl_state_e state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] srx_ff;
    logic long_ff;
    logic first_ff;

    // self refresh exit delay runs alongside anything else, so lock time may overlap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            srx_ff <= '0;
        end else if (sr_exit) begin
            srx_ff <= CNT_W'(SRX_CYC); // RULE12 RULE10
        end else if (srx_ff != '0) begin
            srx_ff <= srx_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CT_IDLE;
            cnt_ff <= '0;
            long_ff <= 1'b0;
            first_ff <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_ff)
                CT_IDLE: begin
                    if (req_valid && banks_idle) begin // RULE9 RULE2
                        long_ff <= req_long;
                        cnt_ff <= CNT_W'(PRE_CYC);
                        state_ff <= CT_PRECHARGE;
                    end
                end
                CT_PRECHARGE: begin
                    if (cnt_ff > CNT_W'(1)) begin
                        cnt_ff <= cnt_ff - CNT_W'(1); // RULE9
                    end else begin
                        state_ff <= CT_SRX_WAIT;
                    end
                end
                CT_SRX_WAIT: begin
                    if (srx_ff == '0 && !peer_rank_busy) begin // RULE12 RULE13
                        state_ff <= CT_ISSUE;
                    end
                end
                CT_ISSUE: begin
                    if (!long_ff) begin
                        cnt_ff <= CNT_W'(SHORT_CYC); // RULE6
                    end else if (first_ff) begin
                        cnt_ff <= CNT_W'(INIT_CYC); // RULE4 RULE1
                    end else begin
                        cnt_ff <= CNT_W'(OPER_CYC); // RULE5
                    end
                    if (long_ff) begin
                        first_ff <= 1'b0;
                    end
                    state_ff <= CT_BUSY;
                end
                CT_BUSY: begin
                    if (cnt_ff > CNT_W'(1)) begin
                        cnt_ff <= cnt_ff - CNT_W'(1); // RULE7 RULE18
                    end else begin
                        done <= 1'b1;
                        state_ff <= CT_IDLE;
                    end
                end
                default: state_ff <= CT_IDLE;
            endcase
        end
    end

    assign link.cal_cmd = state_ff == CT_ISSUE;
    assign link.a10 = state_ff == CT_ISSUE && long_ff; // RULE17
    assign link.cke = 1'b1; // RULE14
    // termination and DQ drivers are tied off in every state, idle included
    assign link.odt = 1'b0; // RULE15
    assign link.dq_oe = 1'b0; // RULE16
    assign link.banks_precharged = state_ff != CT_IDLE && state_ff != CT_PRECHARGE;
    assign rank_busy = state_ff == CT_ISSUE || state_ff == CT_BUSY; // RULE13
    assign req_ready = state_ff == CT_IDLE && banks_idle;
endmodule : zq_controller

// file: verilog/zq_device.sv
// device end: calibration engine sequencing and IO value update
`timescale 1ns/1ps
`include "zq_cfg.svh"
module zq_device import zq_pkg::*; #(
    parameter int CNT_W = `ZQ_CNT_W,
    parameter int INIT_CYC = `ZQ_INIT_CYC,
    parameter int OPER_CYC = `ZQ_OPER_CYC,
    parameter int SHORT_CYC = `ZQ_SHORT_CYC,
    parameter int CODE_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    zq_link_if.dev link,
    input wire logic [CODE_W-1:0] engine_code,
    output logic [CODE_W-1:0] io_code,
    output logic io_update,
    output logic cal_current_en,
    output logic cal_is_long,
    output logic first_done
);
    cal_state_e state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic first_seen_ff;
    logic long_ff;
    logic take;
    logic [CNT_W-1:0] win;

    // only an explicit command starts calibration; nothing in self refresh exit does
    assign take = link.cal_cmd && state_ff == CAL_IDLE; // RULE11
    always_comb begin
        if (!link.a10) begin // RULE17
            win = CNT_W'(SHORT_CYC); // RULE6
        end else if (!first_seen_ff) begin
            win = CNT_W'(INIT_CYC); // RULE4 RULE1
        end else begin
            win = CNT_W'(OPER_CYC); // RULE5
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CAL_IDLE;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                CAL_IDLE: begin
                    if (take) begin
                        state_ff <= CAL_RUN; // RULE3
                        cnt_ff <= win - CNT_W'(2); // RULE18
                    end
                end
                CAL_RUN: begin
                    if (cnt_ff == '0) begin
                        state_ff <= CAL_XFER;
                    end else begin
                        cnt_ff <= cnt_ff - CNT_W'(1);
                    end
                end
                CAL_XFER: state_ff <= CAL_IDLE;
                default: state_ff <= CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_seen_ff <= 1'b0;
            long_ff <= 1'b0;
        end else if (take) begin
            long_ff <= link.a10;
            if (link.a10) begin
                first_seen_ff <= 1'b1; // RULE4
            end
        end
    end

    // results go to the IO only in the last window cycle, so the bus never sees half-done codes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_code <= '0;
            io_update <= 1'b0;
            first_done <= 1'b0;
        end else begin
            io_update <= 1'b0;
            if (state_ff == CAL_RUN && cnt_ff == '0) begin
                io_code <= engine_code; // RULE3
                io_update <= 1'b1;
                if (long_ff) begin
                    first_done <= 1'b1;
                end
            end
        end
    end

    assign cal_current_en = state_ff == CAL_RUN; // RULE8
    assign link.cal_busy = state_ff != CAL_IDLE; // RULE18
    assign cal_is_long = long_ff;
endmodule : zq_device

// file: verilog/zq_link_if.sv
// link between memory controller and calibration sequencer
`timescale 1ns/1ps
interface zq_link_if;
    logic cal_cmd;
    logic a10;
    logic cke;
    logic odt;
    logic dq_oe;
    logic banks_precharged;
    logic cal_busy;
    modport ctrl (output cal_cmd, output a10, output cke, output odt, output dq_oe,
        output banks_precharged, input cal_busy);
    modport dev (input cal_cmd, input a10, input cke, input odt, input dq_oe,
        input banks_precharged, output cal_busy);
endinterface : zq_link_if

// file: verilog/zq_pkg.sv
// state types for the two ends of the calibration link, one enum per end
package zq_pkg;
    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_XFER} cal_state_e;
    typedef enum logic [2:0] {CT_IDLE, CT_PRECHARGE, CT_SRX_WAIT, CT_ISSUE, CT_BUSY} ctl_state_e;
endpackage : zq_pkg
